// ### core/fac_core.sv
// Behaviour
// - conversions start only on host strobe
// - rising strobe edge starts the aperture count; comparator states are latched at its end
// - one parallel 10-bit word per conversion
// - over-range set when input above top reference
// - low select high inverts nine low bits
// - top select high inverts result top bit
// - two selects give four output codings
// - nine bits from 512 comparators, lsb interpolated
// - sample taken fixed delay after strobe edge
`default_nettype none
module fac_core
  import fac_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int COMPS = COMP_COUNT
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // conversion strobe and comparator bank pins
  input wire logic conv_strobe,
  input wire logic [COMPS-1:0] comp_thermo,
  input wire logic [COMPS-1:0] comp_interp,
  input wire logic comp_over,
  // static coding selects
  input wire logic low_bits_flip_select,
  input wire logic top_bit_flip_select,
  // result stream
  output logic [RES_BITS-1:0] result_word_outputs,
  output logic over_range,
  output logic result_valid,
  input wire logic result_ready,
  // status
  output logic conv_busy,
  output logic strobe_missed,
  input wire logic strobe_missed_clear
);
  if (COMPS != COMP_COUNT) begin : g_chk
    $error("fac_core: decoder is built for exactly 512 comparators");
  end

  localparam int NPIN = 2 * COMPS + PIN_THERMO;
  localparam int AC_W = $clog2(APERTURE_CYC + 1);

  // thermometer count of the coarse bank, ten bits wide so a full count of 512 fits
  function automatic logic [COARSE_BITS:0] thermo_count(input logic [COMPS-1:0] th);
    logic [COARSE_BITS:0] n;
    n = '0;
    for (int i = 0; i < COMPS; i++) begin
      n = n + {{COARSE_BITS{1'b0}}, th[i]};
    end
    return n;
  endfunction

  // coarse bits plus the midpoint comparator at the transition
  function automatic logic [RES_BITS-1:0] decode(input logic [COMPS-1:0] th,
                                                 input logic [COMPS-1:0] mid);
    logic [COARSE_BITS:0] n;
    logic [RES_BITS-1:0] code;
    n = thermo_count(th);
    if (n[COARSE_BITS]) begin
      code = {COARSE_MAX, 1'b1};
    end else begin
      code = {n[COARSE_BITS-1:0], mid[n[COARSE_BITS-1:0]]};
    end
    return code;
  endfunction

  function automatic logic [RES_BITS-1:0] apply_coding(input logic [RES_BITS-1:0] bin,
                                                       input fac_coding_t cod);
    logic [RES_BITS-1:0] w;
    w = bin;
    w[LOW_MSB:0] = bin[LOW_MSB:0] ^ {(LOW_MSB + 1){cod.low_flip}};
    w[TOP_BIT] = bin[TOP_BIT] ^ cod.top_flip;
    return w;
  endfunction

  // three-stage pin synchroniser; a bit changes when stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_q_r;

  assign pin_raw = {comp_interp, comp_thermo, comp_over, conv_strobe,
                    low_bits_flip_select, top_bit_flip_select};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r <= '0;
    end else if (clk_en) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r <= (pin_s2_r & pin_s3_r) | (pin_q_r & (pin_s2_r | pin_s3_r));
    end
  end

  fac_coding_t coding;
  logic strobe_q;
  logic over_q;
  logic [COMPS-1:0] thermo_q;
  logic [COMPS-1:0] interp_q;
  logic strobe_d_r;
  logic strobe_rise;

  assign coding.top_flip = pin_q_r[PIN_TOP_SEL];
  assign coding.low_flip = pin_q_r[PIN_LOW_SEL];
  assign strobe_q = pin_q_r[PIN_STROBE];
  assign over_q = pin_q_r[PIN_OVER];
  assign thermo_q = pin_q_r[COMPS+PIN_THERMO-1:PIN_THERMO];
  assign interp_q = pin_q_r[NPIN-1:COMPS+PIN_THERMO];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_d_r <= 1'b0;
    end else if (clk_en) begin
      strobe_d_r <= strobe_q;
    end
  end

  // only a low-to-high change of the strobe starts anything
  assign strobe_rise = strobe_q && !strobe_d_r;

  // conversion sequencer
  fac_state_t state_r;
  fac_state_t state_nxt;
  logic [AC_W-1:0] ap_cnt_r;
  fac_result_t pend_r;
  logic fifo_in_ready;
  logic ap_done;

  assign ap_done = (ap_cnt_r == AC_W'(1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FAC_IDLE: begin
        if (strobe_rise) begin
          state_nxt = FAC_APERTURE;
        end
      end
      FAC_APERTURE: begin
        if (ap_done) begin
          state_nxt = FAC_HOLD;
        end
      end
      FAC_HOLD: begin
        if (fifo_in_ready) begin
          state_nxt = FAC_IDLE;
        end
      end
      default: begin
        state_nxt = FAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= FAC_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // fixed count, independent of data, so parts sharing a strobe sample together
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ap_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r == FAC_IDLE && strobe_rise) begin
        ap_cnt_r <= AC_W'(APERTURE_CYC);
      end else if (state_r == FAC_APERTURE) begin
        ap_cnt_r <= ap_cnt_r - AC_W'(1);
      end
    end
  end

  // sample and decode at the end of the aperture; binary before coding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_r <= '0;
    end else if (clk_en && state_r == FAC_APERTURE && ap_done) begin
      pend_r.code <= apply_coding(decode(thermo_q, interp_q), coding);
      pend_r.over_range <= over_q;
    end
  end

  // a strobe while a conversion is still pending is refused; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_missed <= 1'b0;
    end else if (clk_en) begin
      if (strobe_rise && state_r != FAC_IDLE) begin
        strobe_missed <= 1'b1;
      end else if (strobe_missed_clear) begin
        strobe_missed <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conv_busy <= 1'b0;
    end else if (clk_en) begin
      conv_busy <= (state_nxt != FAC_IDLE);
    end
  end

  // word and flag travel together so the host latches them as one
  fac_result_t fifo_out;

  fac_fifo #(
    .WIDTH($bits(fac_result_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_data(pend_r),
    .in_valid(state_r == FAC_HOLD),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(result_valid),
    .out_ready(result_ready)
  );

  assign result_word_outputs = fifo_out.code;
  assign over_range = fifo_out.over_range;
endmodule // fac_core
`default_nettype wire

// ### core/fac_pkg.sv
`default_nettype none
package fac_pkg;
  localparam int RES_BITS = 10;
  localparam int COARSE_BITS = 9;
  localparam int COMP_COUNT = 512;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 40;
  // fixed aperture delay from the qualified strobe edge to the sample
  localparam int APERTURE_NS = 80;
  localparam int APERTURE_CYC_RAW = (APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APERTURE_CYC = (APERTURE_CYC_RAW < 1) ? 1 : APERTURE_CYC_RAW;
  localparam logic [COARSE_BITS-1:0] COARSE_MAX = 9'h1ff;
  localparam int LOW_MSB = 8;
  localparam int TOP_BIT = 9;
  // bit positions of the pins inside the synchroniser word
  localparam int PIN_TOP_SEL = 0;
  localparam int PIN_LOW_SEL = 1;
  localparam int PIN_STROBE = 2;
  localparam int PIN_OVER = 3;
  localparam int PIN_THERMO = 4;

  typedef struct packed {
    logic over_range;
    logic [RES_BITS-1:0] code;
  } fac_result_t;

  typedef struct packed {
    logic low_flip;
    logic top_flip;
  } fac_coding_t;

  typedef enum logic [1:0] {
    FAC_IDLE = 2'b00,
    FAC_APERTURE = 2'b01,
    FAC_HOLD = 2'b10
  } fac_state_t;
endpackage
`default_nettype wire

// ### core/fac_fifo.sv
`default_nettype none
module fac_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // write side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // read side, data held in a register
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fac_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // the output register counts as one more slot beyond DEPTH
  assign in_ready = (count_r != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_r != '0) && (!out_valid || out_ready);

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clk_en) begin
      if (pop) begin
        out_valid <= 1'b1;
        out_data <= mem_r[rd_ptr_r];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // fac_fifo
`default_nettype wire

// ### tb/fac_checker.sv
`default_nettype none
module fac_checker
  import fac_pkg::*;
(
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  // strobe and status
  input wire logic conv_strobe,
  input wire logic conv_busy,
  input wire logic strobe_missed,
  input wire logic strobe_missed_clear,
  // result stream
  input wire logic [RES_BITS-1:0] result_word_outputs,
  input wire logic over_range,
  input wire logic result_valid,
  input wire logic result_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_word_stands: assert property (
    result_valid && !result_ready |=> result_valid && $stable({over_range, result_word_outputs}))
    else $error("held word changed");
  chk_aperture_fixed: assert property ($rose(conv_busy) |-> conv_busy[*2])
    else $error("aperture cut short");
  chk_strobe_cause: assert property ($rose(conv_busy) |-> $past(conv_strobe, 2))
    else $error("conversion without strobe");
  chk_missed_sticky: assert property (
    strobe_missed && !strobe_missed_clear |=> strobe_missed)
    else $error("missed flag lost");
  chk_missed_cause: assert property ($rose(strobe_missed) |-> $past(conv_busy))
    else $error("missed flag while idle");
  chk_result_follows: assert property ($fell(conv_busy) |-> ##[0:2] result_valid)
    else $error("no word after conversion");
  chk_reset_quiet: assert property (
    $past(rst) |-> !result_valid && !conv_busy && !strobe_missed)
    else $error("outputs active after reset");
  chk_busy_bounded: assert property (conv_busy && result_ready |-> ##[0:10] !conv_busy)
    else $error("conversion hangs");
  cover property (result_valid && result_ready);
  cover property ($rose(strobe_missed));
  cover property (result_valid && over_range);
endmodule // fac_checker
`default_nettype wire

// ### tb/fac_host.sv
`default_nettype none
module fac_host
  import fac_pkg::*;
(
  // clocking
  input wire logic sys_clk,
  input wire logic stall,
  // strobe and result stream
  output logic conv_strobe,
  input wire logic [RES_BITS-1:0] result_word_outputs,
  input wire logic over_range,
  input wire logic result_valid,
  output logic result_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  fac_result_t cap_q[$];
  initial conv_strobe = 1'b0;
  initial result_ready = 1'b0;
  always @(negedge sys_clk) result_ready <= !stall;
  // word and flag latched as one unit
  always @(posedge sys_clk) begin
    if (result_valid && result_ready) cap_q.push_back({over_range, result_word_outputs});
  end
  // wide pulse so the pin synchroniser sees both levels
  task automatic pulse();
    @(negedge sys_clk);
    conv_strobe = 1'b1;
    repeat (6) @(negedge sys_clk);
    conv_strobe = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule // fac_host
`default_nettype wire

// ### tb/flash_adc_output_coding_tb.sv
`default_nettype none
module flash_adc_output_coding_tb import fac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, stall, conv_strobe, comp_over, result_ready;
  logic low_bits_flip_select, top_bit_flip_select, strobe_missed_clear, clk_en;
  logic [COMP_COUNT-1:0] comp_thermo, comp_interp;
  logic [RES_BITS-1:0] result_word_outputs;
  logic over_range, result_valid, conv_busy, strobe_missed;
  int n_fail = 0;
  int checks_done = 0;
  fac_core i_fac_core (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .conv_strobe(conv_strobe),
    .comp_thermo(comp_thermo), .comp_interp(comp_interp), .comp_over(comp_over),
    .low_bits_flip_select(low_bits_flip_select), .top_bit_flip_select(top_bit_flip_select),
    .result_word_outputs(result_word_outputs), .over_range(over_range),
    .result_valid(result_valid), .result_ready(result_ready), .conv_busy(conv_busy),
    .strobe_missed(strobe_missed), .strobe_missed_clear(strobe_missed_clear));
  fac_host i_fac_host (.sys_clk(sys_clk), .stall(stall), .conv_strobe(conv_strobe),
    .result_word_outputs(result_word_outputs), .over_range(over_range),
    .result_valid(result_valid), .result_ready(result_ready));
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [10:0] expect_of(input int n, input logic lsb, input logic ovr);
    logic [9:0] b;
    b = (n >= 512) ? 10'h3ff : {n[8:0], lsb};
    return {ovr, b ^ {top_bit_flip_select, {9{low_bits_flip_select}}}};
  endfunction
  // thermometer of n ones, interpolation bit copied everywhere
  task automatic setin(input int n, input logic lsb, input logic ovr);
    @(negedge sys_clk);
    comp_thermo = (512'h1 << n) - 512'h1;
    comp_interp = {512{lsb}};
    comp_over = ovr;
  endtask
  task automatic take(input logic [10:0] exp);
    int k;
    k = 0;
    while (i_fac_host.cap_q.size() == 0 && k < 60) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 60) begin
      n_fail++;
      $display("ERROR t=%0t no word got=%h exp=%h", $time, 11'h0, exp);
      print_verdict();
    end else check(i_fac_host.cap_q.pop_front(), exp);
  endtask
  task automatic t_codes();
    int tbl[4] = '{0, 256, 511, 512};
    for (int m = 0; m < 4; m++) begin
      {top_bit_flip_select, low_bits_flip_select} = m[1:0];
      for (int j = 0; j < 4; j++) begin
        setin(tbl[j], j[0], j == 3);
        i_fac_host.pulse();
        take(expect_of(tbl[j], j[0], j == 3));
      end
    end
    $display("test codes done");
  endtask
  // fifo plus output register hold 9, one more waits busy, the next is refused
  task automatic t_fill();
    stall = 1'b1;
    for (int i = 0; i < 11; i++) begin
      setin(i, 1'b1, 1'b0);
      i_fac_host.pulse();
    end
    check({10'h0, strobe_missed}, 11'h1);
    stall = 1'b0;
    for (int i = 0; i < 10; i++) take(expect_of(i, 1'b1, 1'b0));
    strobe_missed_clear = 1'b1;
    @(negedge sys_clk);
    strobe_missed_clear = 1'b0;
    check({10'h0, strobe_missed}, 11'h0);
    $display("test fill done");
  endtask
  // a frozen core must ignore a whole strobe pulse, then convert normally again
  task automatic t_freeze();
    @(negedge sys_clk);
    clk_en = 1'b0;
    setin(5, 1'b0, 1'b0);
    i_fac_host.pulse();
    check({conv_busy, result_valid, 9'h0}, 11'h0);
    check({10'h0, i_fac_host.cap_q.size() != 0}, 11'h0);
    clk_en = 1'b1;
    repeat (8) @(negedge sys_clk);
    check({10'h0, conv_busy}, 11'h0);
    setin(5, 1'b0, 1'b0);
    i_fac_host.pulse();
    take(expect_of(5, 1'b0, 1'b0));
    $display("test freeze done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    stall = 1'b0;
    comp_thermo = '0;
    comp_interp = '0;
    comp_over = 1'b0;
    low_bits_flip_select = 1'b0;
    top_bit_flip_select = 1'b0;
    strobe_missed_clear = 1'b0;
    clk_en = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    check({result_valid, conv_busy, strobe_missed, 8'h0}, 11'h0);
    repeat (4) @(negedge sys_clk);
    t_codes();
    t_fill();
    t_freeze();
    print_verdict();
  end
endmodule // flash_adc_output_coding_tb
bind fac_core fac_checker i_fac_checker (
  .sys_clk(sys_clk), .rst(rst), .conv_strobe(conv_strobe), .conv_busy(conv_busy),
  .strobe_missed(strobe_missed), .strobe_missed_clear(strobe_missed_clear),
  .result_word_outputs(result_word_outputs), .over_range(over_range),
  .result_valid(result_valid), .result_ready(result_ready));
`default_nettype wire
